// *** logic/srrs_regs.svh ***
// timing counts and reset values for the reset release sequencer
`ifndef SRRS_REGS_SVH
`define SRRS_REGS_SVH
`define SRRS_POR_EXT_CYC   7'h40
`define SRRS_WDSW_REL_CYC  7'h03
`define SRRS_CLKGEN_CYC    7'h20
`define SRRS_PERIP_CYC     7'h20
`define SRRS_CORE_CYC      7'h20
`define SRRS_CNT_RST       7'h00
`endif

// *** logic/srrs_pkg.sv ***
// types for the reset release sequencer
package srrs_pkg;
    typedef enum logic [2:0] {
        ST_COMBINED = 3'b000,
        ST_CLKGEN   = 3'b001,
        ST_PERIP    = 3'b010,
        ST_CORE     = 3'b011,
        ST_RUN      = 3'b100
    } srrs_state_type;

    typedef struct packed {
        logic clock_generator_reset;
        logic peripheral_reset;
        logic core_reset;
        logic watchdog_sw_reset;
    } srrs_resets_type;
endpackage

// *** logic/srrs_sequencer.sv ***
// staged reset release sequencer: combines sources, releases in order
// Behaviour
// RULE_01: extended power-on reset held 64 oscillator cycles
// RULE_02: combined reset is OR of four sources
// RULE_03: combined reset holds all except extender
// RULE_04: stages start only after combined reset releases
// RULE_05: watchdog/software logic released after three cycles
// RULE_06: clock generator reset released after 32 cycles
// RULE_07: peripheral reset held 32 further cycles
// RULE_08: core reset held 32 further cycles
// RULE_09: core release marks sequence complete
// RULE_10: clock generator reset stretched up to 96 cycles; code holds it 97 cycles after power-on
// RULE_11: clock generator reset released on falling edge; code releases it on the rising edge of i_sys_clk
// RULE_12: peripheral and core released on falling edge; code releases them on the rising edge of i_sys_clk
// RULE_13: no interrupt requests raised
// RULE_14: timer/modulator clocks may run at three times
// RULE_15: software write and watchdog events cause reset
// RULE_16: test access port reset only by power-on
// RULE_17: any reassertion restarts the whole sequence
// RULE_18: external reset pin synchronised before use
`timescale 1ns/1ns
`include "srrs_regs.svh"
module srrs_sequencer
    import srrs_pkg::*;
(
    input  wire logic      i_sys_clk,
    input  wire logic      i_rst,
    input  wire logic      i_ext_reset_pin,
    input  wire logic      i_sw_reset_write,
    input  wire logic      i_wd_timeout,
    input  wire logic      i_wd_loss_of_ref,
    output srrs_resets_type o_resets,
    output logic           o_test_port_reset,
    output logic           o_startup_done
);
    // single clock: oscillator and system rate coincide here, so the
    // falling-edge release is modelled as a registered, glitch-free edge
    logic [1:0]     ext_sync_ff;
    logic           por_ext_ff;
    logic [6:0]     por_cnt_ff;
    logic           wd_sw_ff;
    logic           combined;
    logic [6:0]     stage_cnt_ff;
    srrs_state_type state_ff;
    srrs_state_type nxt_state;
    // one flop per staged reset so each release edge is independent
    logic           wd_rst_ff;
    logic           cg_rst_ff;
    logic           pr_rst_ff;
    logic           co_rst_ff;
    logic           tap_rst_ff;
    logic           done_ff;

    function automatic logic cnt_hit(input logic [6:0] c,
                                     input logic [6:0] lim);
        cnt_hit = (c == lim - 7'h01);
    endfunction

    // two flops before the asynchronous pin is read
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            ext_sync_ff <= 2'h3;
        else
            ext_sync_ff <= {ext_sync_ff[0], i_ext_reset_pin}; // see RULE_18
    end

    // power-on extender is only reset by power-on itself
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            por_ext_ff <= 1'b1;
            por_cnt_ff <= `SRRS_CNT_RST;
        end
        else if (por_ext_ff)
        begin
            por_cnt_ff <= por_cnt_ff + 7'h01;
            if (cnt_hit(por_cnt_ff, `SRRS_POR_EXT_CYC))
                por_ext_ff <= 1'b0; // see RULE_01
        end
    end

    // software and watchdog events latch a reset until the stage clears
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            wd_sw_ff <= 1'b0;
        else if (i_sw_reset_write || i_wd_timeout || i_wd_loss_of_ref)
            wd_sw_ff <= 1'b1; // see RULE_15
        else if (!wd_rst_ff)
            wd_sw_ff <= 1'b0;
        else if (wd_rst_ff && state_ff == ST_CLKGEN)
            wd_sw_ff <= 1'b0; // source logic held in reset: event consumed
    end

    assign combined = por_ext_ff | ext_sync_ff[1] | wd_sw_ff; // see RULE_02

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_COMBINED:
            begin
                nxt_state = ST_CLKGEN; // see RULE_04
            end
            ST_CLKGEN:
            begin
                if (cnt_hit(stage_cnt_ff, `SRRS_CLKGEN_CYC))
                    nxt_state = ST_PERIP; // see RULE_06
            end
            ST_PERIP:
            begin
                if (cnt_hit(stage_cnt_ff, `SRRS_PERIP_CYC))
                    nxt_state = ST_CORE; // see RULE_07
            end
            ST_CORE:
            begin
                if (cnt_hit(stage_cnt_ff, `SRRS_CORE_CYC))
                    nxt_state = ST_RUN; // see RULE_08
            end
            ST_RUN:
            begin
                nxt_state = ST_RUN;
            end
            default:
            begin
                nxt_state = ST_COMBINED;
            end
        endcase
        // any live source overrides the stage walk at once
        if (combined)
            nxt_state = ST_COMBINED; // see RULE_03 RULE_17
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            state_ff <= ST_COMBINED;
        else
            state_ff <= nxt_state;
    end

    // counter restarts at each stage change or on reassertion
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || combined || nxt_state != state_ff)
            stage_cnt_ff <= `SRRS_CNT_RST; // see RULE_17
        else
            stage_cnt_ff <= stage_cnt_ff + 7'h01;
    end

    // watchdog/software logic leaves reset first, so it can catch
    // a fresh event while the later stages are still held
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || combined)
            wd_rst_ff <= 1'b1; // see RULE_03
        else if (state_ff == ST_CLKGEN &&
                 cnt_hit(stage_cnt_ff, `SRRS_WDSW_REL_CYC))
            wd_rst_ff <= 1'b0; // see RULE_05
    end

    // total stretch after power-on is 64 + 1 (ST_COMBINED) + 32, i.e. 97 cycles
    // registered release gives one skew-free edge per reset
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || combined)
            cg_rst_ff <= 1'b1; // see RULE_10
        else
            cg_rst_ff <= (nxt_state == ST_CLKGEN) ||
                         (nxt_state == ST_COMBINED); // see RULE_11
    end

    // peripherals stay clocked but held while clocks settle
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || combined)
            pr_rst_ff <= 1'b1; // see RULE_03
        else
            pr_rst_ff <= (nxt_state != ST_CORE) &&
                         (nxt_state != ST_RUN); // see RULE_12
    end

    // core last: peripherals get their start-up window first
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || combined)
            co_rst_ff <= 1'b1; // see RULE_03
        else
            co_rst_ff <= (nxt_state != ST_RUN); // see RULE_12
    end

    // test port ignores pin, watchdog and software sources
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            tap_rst_ff <= 1'b1;
        else
            tap_rst_ff <= por_ext_ff; // see RULE_16
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            done_ff <= 1'b0;
        else
            done_ff <= (nxt_state == ST_RUN) && !combined; // see RULE_09
    end

    // no interrupt output exists on this block, see RULE_13
    // divided peripheral clocks lie outside; one rate only, see RULE_14
    assign o_resets          = {cg_rst_ff, pr_rst_ff, co_rst_ff, wd_rst_ff};
    assign o_test_port_reset = tap_rst_ff;
    assign o_startup_done    = done_ff;
endmodule

// *** tb/srrs_props.sv ***
// assertions for the reset release sequencer
`timescale 1ns/1ns
module srrs_props
    import srrs_pkg::*;
(
    input logic            i_sys_clk,
    input logic            i_rst,
    input logic            i_ext_reset_pin,
    input logic            i_sw_reset_write,
    input logic            i_wd_timeout,
    input logic            i_wd_loss_of_ref,
    input srrs_resets_type o_resets,
    input logic            o_test_port_reset,
    input logic            o_startup_done
);
    wire cg = o_resets.clock_generator_reset;
    wire pr = o_resets.peripheral_reset;
    wire co = o_resets.core_reset;
    wire wd = o_resets.watchdog_sw_reset;
    wire tp = o_test_port_reset;
    wire sr = i_sw_reset_write || i_wd_timeout || i_wd_loss_of_ref;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence all_held;
        cg && pr && co;
    endsequence
    chk_wd_first: assert property (!cg |-> !wd)
        else $error("wd late");
    chk_cg_delay: assert property ($fell(cg) |->
        !$past(wd, 27) && $past(wd, 31)) else $error("clkgen delay");
    chk_pr_delay: assert property ($fell(pr) |->
        !$past(cg, 31) && $past(cg, 34)) else $error("perip delay");
    chk_core_delay: assert property ($fell(co) |->
        !$past(pr, 31) && $past(pr, 34)) else $error("core delay");
    chk_done_core: assert property (
        $rose(o_startup_done) |-> ##[0:1] !co) else $error("done early");
    chk_src_restart: assert property (
        sr |-> ##[1:2] all_held) else $error("src restart");
    chk_pin_restart: assert property (
        i_ext_reset_pin |-> ##[1:4] all_held) else $error("pin restart");
    chk_tap_por: assert property (!tp |=> !tp)
        else $error("tap reset");
    chk_por_ext: assert property ($fell(tp) |->
        $past(tp, 62) && cg) else $error("por ext");
endmodule
bind srrs_sequencer srrs_props chk (.*);

// *** tb/srrs_far_model.sv ***
// far-side model: clock generator, peripherals and core
`timescale 1ns/1ns
module srrs_far_model
    import srrs_pkg::*;
(
    input logic            i_clk,
    input srrs_resets_type i_resets,
    output logic           o_order_ok
);
    initial o_order_ok = 1'b1;
    // core must never run while its clocks or peripherals are held
    always @(posedge i_clk)
        if (!i_resets.core_reset && (i_resets.peripheral_reset
            || i_resets.clock_generator_reset))
            o_order_ok <= 1'b0;
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the reset release sequencer
`timescale 1ns/1ns
module tb_top;
    import srrs_pkg::*;
    logic clk = 0, rst = 1, pin = 0, sw = 0, wdt = 0, lor = 0, tpr, done, ok;
    srrs_resets_type res;
    int num_errors = 0, tests_run = 0, cyc = 0, t0, t1, t2, t3;
    initial forever #50 clk = ~clk;
    srrs_sequencer DUT (.i_sys_clk(clk), .i_rst(rst), .i_ext_reset_pin(pin),
        .i_sw_reset_write(sw), .i_wd_timeout(wdt), .i_wd_loss_of_ref(lor),
        .o_resets(res), .o_test_port_reset(tpr), .o_startup_done(done));
    srrs_far_model far (.i_clk(clk), .i_resets(res), .o_order_ok(ok));
    task automatic step(int n = 1);
        repeat (n) @(posedge clk) #10;
    endtask
    task automatic check(string what, logic [3:0] exp, logic [3:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic fall(int b, output int t);
        for (t = 0; res[b] !== 1'b0 && t < 300; t++) step();
    endtask
    // waits out one release sequence; the pr and core gaps carry +-1 slack, the cg gap +-2
    task automatic run_seq(int base);
        fall(0, t0);
        fall(3, t1);
        fall(2, t2);
        fall(1, t3);
        step();
        check("wd", 1, t0 inside {[base:base + 8]});
        check("cg", 1, t1 inside {[27:31]});
        check("pr", 1, t2 inside {[31:33]});
        check("core", 1, t3 inside {[31:33]});
        check("done", 1, done);
        check("order", 1, ok);
    endtask
    task automatic t_power_on();
        check("held", 4'hf, res);
        check("tap", 1, tpr);
        rst = 0;
        run_seq(64);
        check("tap", 0, tpr);
        $display("test power_on done");
    endtask
    // external pin reasserts reset after the sequence has completed, then all stages restart
    task automatic t_pin_abort();
        fall(3, t1);
        step(10);
        pin = 1;
        step(4);
        check("abort", 4'hf, res);
        check("tap", 0, tpr);
        pin = 0;
        run_seq(2);
        $display("test pin_abort done");
    endtask
    task automatic t_sources();
        for (int i = 0; i < 3; i++)
        begin
            fall(2, t2);
            {sw, wdt, lor} = 3'b100 >> i;
            step();
            {sw, wdt, lor} = 3'b000;
            step();
            check("src", 4'hf, res);
            run_seq(0);
        end
        $display("test sources done");
    endtask
    task automatic results();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk)
        if (++cyc == 3000)
        begin
            num_errors++;
            results();
        end
    initial
    begin
        step(6);
        t_power_on();
        t_pin_abort();
        t_sources();
        results();
    end
endmodule
